// ---- src/dpg_gpio.sv ----
// Purpose: two gpio ports with alternate-function steering, ahb-lite slave
// Assumes: pins and timer signals synchronous to hclk, word accesses only
// Notes:   zero wait states; pin and alternate outputs lag one cycle
`default_nettype none
module dpg_gpio (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic      [31:0]              hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  input  wire logic [dpg_pkg::P7_W-1:0] p7_pin_in,
  output logic      [dpg_pkg::P7_W-1:0] p7_pin_out,
  output logic      [dpg_pkg::P7_W-1:0] p7_pin_oe,
  input  wire logic [dpg_pkg::P8_W-1:0] p8_pin_in,
  output logic      [dpg_pkg::P8_W-1:0] p8_pin_out,
  output logic      [dpg_pkg::P8_W-1:0] p8_pin_oe,
  input  wire logic                     timer01_out,
  input  wire logic                     timer23_out,
  input  wire logic                     timer45_out,
  input  wire logic                     wide_timer_a_out_a,
  input  wire logic                     wide_timer_a_out_b,
  input  wire logic                     wide_timer_b_out_a,
  input  wire logic                     wide_timer_b_out_b,
  output logic                          timer01_clock_in,
  output logic                          timer45_clock_in,
  output logic                          wide_timer_a_capture_a,
  output logic                          wide_timer_a_capture_b,
  output logic                          wide_timer_b_capture_a,
  output logic                          wide_timer_b_capture_b,
  output logic                          ext_irq_zero,
  output logic                          ext_irq_five,
  output logic                          ext_irq_six,
  output logic                          ext_irq_seven,
  output logic                          ext_irq_eight,
  output logic                          irq
);
  import dpg_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [P7_W-1:0]  p7_latch;
    logic [P7_W-1:0]  p7_dir;
    logic [P7_W-1:0]  p7_func;
    logic [P8_W-1:0]  p8_latch;
    logic [P8_W-1:0]  p8_dir;
    logic [P8_W-1:0]  p8_func;
    logic [1:0]       mode;
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] mask;
    logic             wr_pend;
    logic [7:0]       wr_idx;
    logic [31:0]      rdata;
    logic [P7_W-1:0]  p7_out;
    logic [P7_W-1:0]  p7_oe;
    logic [P8_W-1:0]  p8_out;
    logic [P8_W-1:0]  p8_oe;
    logic [1:0]       tin;
    logic [3:0]       cap;
    logic             irq0;
    logic             irq_out;
  } dpg_state_s;
  dpg_state_s st_ff;
  dpg_state_s nxt_st;
  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic dpg_word_ok(input logic [31:0] a);
    dpg_word_ok = (a[1:0] == 2'h0) && (a[31:10] == 22'h00_0000);
  endfunction
  function automatic logic [7:0] dpg_idx(input logic [31:0] a);
    dpg_idx = a[9:2];
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // pin steering
  logic [P7_W-1:0] p7_mux_out;
  logic [P7_W-1:0] p7_mux_oe;
  logic [P7_W-1:0] p7_alt_in;
  logic [P7_W-1:0] p7_alt_src;
  logic [P8_W-1:0] p8_mux_out;
  logic [P8_W-1:0] p8_mux_oe;
  logic [P8_W-1:0] p8_alt_in;
  logic [P8_W-1:0] p8_alt_src;
  logic            irq0_hit;
  assign p7_alt_src = {1'b0, timer45_out, 1'b0, timer23_out, timer01_out, 1'b0};
  assign p8_alt_src = {wide_timer_b_out_b, wide_timer_b_out_a, 2'b00,
                       wide_timer_a_out_b, wide_timer_a_out_a, 2'b00};
  dpg_pin_mux #(
    .W         (P7_W),
    .OUT_LEGAL (P7_OUT_LEGAL),
    .IN_LEGAL  (P7_IN_LEGAL)
  ) u_p7_mux (
    .latch     (st_ff.p7_latch),
    .dir       (st_ff.p7_dir),
    .func      (st_ff.p7_func),
    .alt_out   (p7_alt_src),
    .pin_out   (p7_mux_out),
    .pin_oe    (p7_mux_oe),
    .alt_in_en (p7_alt_in)
  );
  dpg_pin_mux #(
    .W         (P8_W),
    .OUT_LEGAL (P8_OUT_LEGAL),
    .IN_LEGAL  (P8_IN_LEGAL)
  ) u_p8_mux (
    .latch     (st_ff.p8_latch),
    .dir       (st_ff.p8_dir),
    .func      (st_ff.p8_func),
    .alt_out   (p8_alt_src),
    .pin_out   (p8_mux_out),
    .pin_oe    (p8_mux_oe),
    .alt_in_en (p8_alt_in)
  );
  dpg_irq_detect u_irq0 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .en      (p7_alt_in[5]),
    .lvl     (p7_pin_in[5]),
    .mode    (st_ff.mode),
    .hit     (irq0_hit)
  );
  ////////////////////////////////////////////////////////////////////////////
  // next state
  logic             addr_ok;
  logic [7:0]       a_idx;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;
  logic [3:0]       cap_n;
  always_comb begin
    nxt_st  = st_ff;
    addr_ok = hsel && hready && htrans[1];
    a_idx   = dpg_idx(haddr);
    clr     = '0;
    // data phase write lands here
    if (st_ff.wr_pend) begin
      unique case (st_ff.wr_idx)
        IDX_P7_DATA: nxt_st.p7_latch = hwdata[P7_W-1:0];
        IDX_P7_DIR:  nxt_st.p7_dir   = hwdata[P7_W-1:0];
        IDX_P7_FUNC: nxt_st.p7_func  = hwdata[P7_W-1:0] & P7_FUNC_MASK;
        IDX_P8_DATA: nxt_st.p8_latch = hwdata[P8_W-1:0];
        IDX_P8_DIR:  nxt_st.p8_dir   = hwdata[P8_W-1:0];
        IDX_P8_FUNC: nxt_st.p8_func  = hwdata[P8_W-1:0] & P8_FUNC_MASK;
        IDX_IRQ_MODE: nxt_st.mode    = hwdata[1:0];
        IDX_IRQ_STAT: clr            = hwdata[IRQ_W-1:0];
        IDX_IRQ_MASK: nxt_st.mask    = hwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    nxt_st.wr_pend = addr_ok && hwrite && dpg_word_ok(haddr);
    nxt_st.wr_idx  = a_idx;
    // read data prepared in address phase; direction and function registers read as zero
    nxt_st.rdata = 32'h0000_0000;
    if (addr_ok && !hwrite && dpg_word_ok(haddr)) begin
      unique case (a_idx)
        IDX_P7_DATA:  nxt_st.rdata[P7_W-1:0]  = p7_pin_in;
        IDX_P8_DATA:  nxt_st.rdata[P8_W-1:0]  = p8_pin_in;
        IDX_IRQ_MODE: nxt_st.rdata[1:0]       = st_ff.mode;
        IDX_IRQ_STAT: nxt_st.rdata[IRQ_W-1:0] = st_ff.status;
        IDX_IRQ_MASK: nxt_st.rdata[IRQ_W-1:0] = st_ff.mask;
        default: ;
      endcase
    end
    // registered pin drive
    nxt_st.p7_out = p7_mux_out;
    nxt_st.p7_oe  = p7_mux_oe;
    nxt_st.p8_out = p8_mux_out;
    nxt_st.p8_oe  = p8_mux_oe;
    // 8-bit timer inputs have no function bit
    nxt_st.tin = {p7_pin_in[3] & ~st_ff.p7_dir[3],
                  p7_pin_in[0] & ~st_ff.p7_dir[0]};
    cap_n = {p8_pin_in[5] & p8_alt_in[5], p8_pin_in[4] & p8_alt_in[4],
             p8_pin_in[1] & p8_alt_in[1], p8_pin_in[0] & p8_alt_in[0]};
    nxt_st.cap  = cap_n;
    nxt_st.irq0 = irq0_hit;
    // events: irq zero detect, rising edges of routed capture inputs
    ev = {cap_n & ~st_ff.cap, irq0_hit};
    // set wins over the write-one clear
    nxt_st.status  = (st_ff.status & ~clr) | ev;
    nxt_st.irq_out = |(nxt_st.status & nxt_st.mask);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff          <= '0;
      st_ff.p7_latch <= RST_LATCH[P7_W-1:0];
      st_ff.p7_dir   <= RST_DIR[P7_W-1:0];
      st_ff.p7_func  <= RST_FUNC[P7_W-1:0];
      st_ff.p8_latch <= RST_LATCH[P8_W-1:0];
      st_ff.p8_dir   <= RST_DIR[P8_W-1:0];
      st_ff.p8_func  <= RST_FUNC[P8_W-1:0];
      st_ff.mode     <= RST_MODE;
      st_ff.p7_out   <= RST_LATCH[P7_W-1:0];
      st_ff.p8_out   <= RST_LATCH[P8_W-1:0];
    end else begin
      st_ff <= nxt_st;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign hrdata                 = st_ff.rdata;
  assign hreadyout              = 1'b1;
  assign hresp                  = 1'b0;
  assign p7_pin_out             = st_ff.p7_out;
  assign p7_pin_oe              = st_ff.p7_oe;
  assign p8_pin_out             = st_ff.p8_out;
  assign p8_pin_oe              = st_ff.p8_oe;
  assign timer01_clock_in       = st_ff.tin[0];
  assign timer45_clock_in       = st_ff.tin[1];
  assign wide_timer_a_capture_a = st_ff.cap[0];
  assign wide_timer_a_capture_b = st_ff.cap[1];
  assign wide_timer_b_capture_a = st_ff.cap[2];
  assign wide_timer_b_capture_b = st_ff.cap[3];
  assign ext_irq_five           = st_ff.cap[0];
  assign ext_irq_six            = st_ff.cap[1];
  assign ext_irq_seven          = st_ff.cap[2];
  assign ext_irq_eight          = st_ff.cap[3];
  assign ext_irq_zero           = st_ff.irq0;
  assign irq                    = st_ff.irq_out;
  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rst_seen_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_seen_ff <= 1'b0;
    end else begin
      rst_seen_ff <= 1'b1;
    end
  end
  sequence s_wr(logic [7:0] idx);
    hsel && hready && htrans[1] && hwrite && haddr == {22'h0, idx, 2'b00};
  endsequence
  sequence s_rd(logic [7:0] idx);
    hsel && hready && htrans[1] && !hwrite && haddr == {22'h0, idx, 2'b00};
  endsequence
  property p_p7_in_after_reset;
    !rst_seen_ff |-> p7_pin_oe == '0 && p8_pin_oe == '0;
  endproperty
  a_p7_in_after_reset: assert property (p_p7_in_after_reset)
    else $error("pins not inputs after reset");
  property p_latch_reset;
    !rst_seen_ff |-> st_ff.p7_latch == 6'h3f && st_ff.p8_latch == 8'hff;
  endproperty
  a_latch_reset: assert property (p_latch_reset)
    else $error("output latch not all ones after reset");
  property p_ctl_reset;
    !rst_seen_ff |-> st_ff.p7_dir == '0 && st_ff.p7_func == '0
                     && st_ff.p8_dir == '0 && st_ff.p8_func == '0;
  endproperty
  a_ctl_reset: assert property (p_ctl_reset)
    else $error("direction or function not zero after reset");
  property p_dir_write;
    s_wr(IDX_P8_DIR) ##1 1'b1 |=> st_ff.p8_dir == $past(hwdata[7:0]);
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("port eight direction write lost");
  property p_ctl_reads_zero;
    s_rd(IDX_P7_DIR) or s_rd(IDX_P8_FUNC) |=> hrdata == 32'h0000_0000;
  endproperty
  a_ctl_reads_zero: assert property (p_ctl_reads_zero)
    else $error("write-only register read not zero");
  property p_data_read;
    s_rd(IDX_P8_DATA) |=> hrdata == {24'h0, $past(p8_pin_in)};
  endproperty
  a_data_read: assert property (p_data_read)
    else $error("data read not pin level");
  property p_oe_follows_dir;
    st_ff.p8_func == '0 |=> p8_pin_oe == $past(st_ff.p8_dir)
                            && p8_pin_out == $past(st_ff.p8_latch);
  endproperty
  a_oe_follows_dir: assert property (p_oe_follows_dir)
    else $error("plain port drive wrong");
  property p_timer_out;
    st_ff.p7_func[1] && st_ff.p7_dir[1] |=> p7_pin_out[1] == $past(timer01_out);
  endproperty
  a_timer_out: assert property (p_timer_out)
    else $error("timer01 output not on pin");
  property p_tin_forward;
    !st_ff.p7_dir[0] |=> timer01_clock_in == $past(p7_pin_in[0]);
  endproperty
  a_tin_forward: assert property (p_tin_forward)
    else $error("timer01 input not forwarded");
  property p_capture;
    !(st_ff.p8_func[4] && !st_ff.p8_dir[4]) |=> !wide_timer_b_capture_a;
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture routed while disabled");
  property p_rsv_input;
    st_ff.p7_func[5] && st_ff.p7_dir[5] |=> !p7_pin_oe[5];
  endproperty
  a_rsv_input: assert property (p_rsv_input)
    else $error("reserved combination drives pin");
  property p_high_level;
    p7_alt_in[5] && st_ff.mode == 2'b10 && p7_pin_in[5] |=> ext_irq_zero;
  endproperty
  a_high_level: assert property (p_high_level)
    else $error("high level not detected");
  property p_low_level;
    p7_alt_in[5] && st_ff.mode == 2'b11 && !p7_pin_in[5] |=> ext_irq_zero;
  endproperty
  a_low_level: assert property (p_low_level)
    else $error("low level not detected");
  // edge needs one enabled cycle of history before it counts
  sequence s_rise_seen;
    p7_alt_in[5] && st_ff.mode == 2'b00 && !p7_pin_in[5]
    ##1 p7_alt_in[5] && st_ff.mode == 2'b00 && p7_pin_in[5];
  endsequence
  property p_rise_edge;
    s_rise_seen |=> ext_irq_zero;
  endproperty
  a_rise_edge: assert property (p_rise_edge)
    else $error("rising edge not detected");
  property p_masked_quiet;
    st_ff.mask == '0 && !st_ff.wr_pend |=> !irq;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("interrupt raised while all masked");
endmodule
`default_nettype wire

// ---- src/dpg_pkg.sv ----
// Purpose: shared constants for the two-port pin-mux gpio block
// Assumes: 32-bit ahb-lite slave, register index times four is byte address
// Notes:   offsets are indices; reserved bits read as zero
`default_nettype none
package dpg_pkg;
  localparam int unsigned P7_W = 6;
  localparam int unsigned P8_W = 8;
  localparam int unsigned IRQ_W = 5;
  ////////////////////////////////////////////////////////////////////////////
  // register indices
  localparam logic [7:0] IDX_P7_DATA = 8'h1c;
  localparam logic [7:0] IDX_P7_DIR  = 8'h1e;
  localparam logic [7:0] IDX_P7_FUNC = 8'h1f;
  localparam logic [7:0] IDX_P8_DATA = 8'h20;
  localparam logic [7:0] IDX_P8_DIR  = 8'h22;
  localparam logic [7:0] IDX_P8_FUNC = 8'h23;
  localparam logic [7:0] IDX_IRQ_MODE = 8'h24;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h25;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h26;
  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_LATCH = 8'hff;
  localparam logic [7:0] RST_DIR   = 8'h00;
  localparam logic [7:0] RST_FUNC  = 8'h00;
  localparam logic [1:0] RST_MODE  = 2'h0;
  ////////////////////////////////////////////////////////////////////////////
  // implemented function bits and legal alternate combinations
  localparam logic [5:0] P7_FUNC_MASK = 6'h36;
  localparam logic [5:0] P7_OUT_LEGAL = 6'h16;
  localparam logic [5:0] P7_IN_LEGAL  = 6'h20;
  localparam logic [5:0] P7_TIN_BITS  = 6'h09;
  localparam logic [7:0] P8_FUNC_MASK = 8'hff;
  localparam logic [7:0] P8_OUT_LEGAL = 8'hcc;
  localparam logic [7:0] P8_IN_LEGAL  = 8'h33;
  // mode field: bit1 level/edge, bit0 polarity
  localparam int unsigned MODE_LVL_BIT = 1;
  localparam int unsigned MODE_POL_BIT = 0;
  // status bit positions
  localparam int unsigned ST_IRQ0 = 0;
  localparam int unsigned ST_IRQ5 = 1;
endpackage
`default_nettype wire

// ---- src/dpg_pin_mux.sv ----
// Purpose: per-port direction/function pin steering
// Assumes: legal masks describe alternate-function combinations
// Notes:   combinational; the top registers every result
`default_nettype none
module dpg_pin_mux #(
  parameter int unsigned W         = 8,
  parameter logic [W-1:0] OUT_LEGAL = '0,
  parameter logic [W-1:0] IN_LEGAL  = '0
) (
  input  wire logic [W-1:0] latch,
  input  wire logic [W-1:0] dir,
  input  wire logic [W-1:0] func,
  input  wire logic [W-1:0] alt_out,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe,
  output logic      [W-1:0] alt_in_en
);
  logic [W-1:0] out_alt;
  logic [W-1:0] rsv;
  always_comb begin
    out_alt   = func & dir & OUT_LEGAL;
    // reserved combinations fall back to plain input
    rsv       = func & ((dir & ~OUT_LEGAL) | (~dir & ~IN_LEGAL));
    pin_oe    = dir & ~rsv;
    pin_out   = (out_alt & alt_out) | (~out_alt & latch);
    alt_in_en = func & ~dir & IN_LEGAL;
  end
endmodule
`default_nettype wire

// ---- src/dpg_irq_detect.sv ----
// Purpose: edge or level detector for the port-seven interrupt input
// Assumes: pin is synchronous to hclk
// Notes:   disabled input forgets its history to avoid a false edge
`default_nettype none
module dpg_irq_detect (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       en,
  input  wire logic       lvl,
  input  wire logic [1:0] mode,
  output logic            hit
);
  import dpg_pkg::*;
  typedef struct packed {
    logic prev;
    logic seen;
  } dpg_det_s;
  dpg_det_s st_ff;
  dpg_det_s nxt_st;
  always_comb begin
    nxt_st.prev = lvl;
    nxt_st.seen = en;
    hit = 1'b0;
    if (en) begin
      if (mode[MODE_LVL_BIT]) begin
        hit = lvl ^ mode[MODE_POL_BIT];
      end else if (st_ff.seen) begin
        hit = mode[MODE_POL_BIT] ? (st_ff.prev & ~lvl)
                                 : (~st_ff.prev & lvl);
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/dpg_pin_partner.sv ----
// Purpose: far-side model of the package pins of both ports
// Assumes: bench always drives the outside level, so no pull resistors
// Notes:   a driven pin reads back what the block drives
`default_nettype none
module dpg_pin_partner (
  input  wire logic [5:0] p7_out,
  input  wire logic [5:0] p7_oe,
  input  wire logic [5:0] p7_ext,
  output logic      [5:0] p7_in,
  input  wire logic [7:0] p8_out,
  input  wire logic [7:0] p8_oe,
  input  wire logic [7:0] p8_ext,
  output logic      [7:0] p8_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // enable high means the block owns the wire
  assign p7_in = (p7_out & p7_oe) | (p7_ext & ~p7_oe);
  assign p8_in = (p8_out & p8_oe) | (p8_ext & ~p8_oe);
endmodule
`default_nettype wire

// ---- testbench/dual_port_pin_mux_gpio_test.sv ----
// Purpose: register-level bench for the two-port gpio
// Assumes: zero wait states, but the master still waits on hready
// Notes:   pin loopback comes from the partner model
`default_nettype none
module dual_port_pin_mux_gpio_test;
  timeunit 1ns;
  timeprecision 100ps;
  import dpg_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [5:0]  p7_in, p7_out, p7_oe, ext7;
  logic [7:0]  p8_in, p8_out, p8_oe, ext8;
  logic [2:0]  t8;
  logic [3:0]  t16, cap;
  logic [4:0]  eirq;
  logic        tc01, tc45, irq;
  int          num_errors, checked;
  ////////////////////////////////////////////////////////////////////////////
  dpg_gpio dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .p7_pin_in(p7_in), .p7_pin_out(p7_out), .p7_pin_oe(p7_oe),
    .p8_pin_in(p8_in), .p8_pin_out(p8_out), .p8_pin_oe(p8_oe),
    .timer01_out(t8[0]), .timer23_out(t8[1]), .timer45_out(t8[2]),
    .wide_timer_a_out_a(t16[0]), .wide_timer_a_out_b(t16[1]),
    .wide_timer_b_out_a(t16[2]), .wide_timer_b_out_b(t16[3]),
    .timer01_clock_in(tc01), .timer45_clock_in(tc45),
    .wide_timer_a_capture_a(cap[3]), .wide_timer_a_capture_b(cap[2]),
    .wide_timer_b_capture_a(cap[1]), .wide_timer_b_capture_b(cap[0]),
    .ext_irq_zero(eirq[4]), .ext_irq_five(eirq[3]), .ext_irq_six(eirq[2]),
    .ext_irq_seven(eirq[1]), .ext_irq_eight(eirq[0]), .irq(irq)
  );
  dpg_pin_partner u_pins (
    .p7_out(p7_out), .p7_oe(p7_oe), .p7_ext(ext7), .p7_in(p7_in),
    .p8_out(p8_out), .p8_oe(p8_oe), .p8_ext(ext8), .p8_in(p8_in)
  );
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // one single transfer; waits on hready, never on a fixed count
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(idx, 1'b1, d, x);
  endtask
  task automatic rd(input logic [7:0] idx);
    bus(idx, 1'b0, 32'h0000_0000, rv);
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(8 * 5000);
    num_errors++;
    print_verdict();
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    ext7 = 6'h2a;
    ext8 = 8'h00;
    t8 = 3'h5;
    t16 = 4'h9;
    num_errors = 0;
    checked = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    pause(1);
    chk(32'(p7_oe), 32'h0000_0000);
    chk(32'(p8_oe), 32'h0000_0000);
    chk(32'(p7_out), 32'h0000_003f);
    chk(32'(p8_out), 32'h0000_00ff);
    chk(32'(hresp), 32'h0000_0000);
    rd(IDX_P7_DATA);
    chk(rv, 32'h0000_002a);
    rd(IDX_P8_DATA);
    chk(rv, 32'h0000_0000);
    rd(IDX_P7_DIR);
    chk(rv, 32'h0000_0000);
    rd(IDX_P8_FUNC);
    chk(rv, 32'h0000_0000);
    rd(8'hff);
    chk(rv, 32'h0000_0000);
    // latch first, then direction: pins come up driving the written value
    wr(IDX_P7_DATA, 32'h0000_0015);
    wr(IDX_P7_DIR, 32'h0000_003f);
    pause(2);
    chk(32'(p7_oe), 32'h0000_003f);
    chk(32'(p7_out), 32'h0000_0015);
    chk(32'(tc01), 32'h0000_0000);
    rd(IDX_P7_DATA);
    chk(rv, 32'h0000_0015);
    wr(IDX_P7_DIR, 32'h0000_0000);
    pause(2);
    chk(32'({tc45, tc01}), 32'h0000_0002);
    wr(IDX_P7_FUNC, 32'h0000_0016);
    wr(IDX_P7_DIR, 32'h0000_0016);
    pause(2);
    chk(32'(p7_oe), 32'h0000_0016);
    chk(32'(p7_out & 6'h16), 32'h0000_0012);
    t8 <= 3'h2;
    pause(2);
    chk(32'(p7_out & 6'h16), 32'h0000_0004);
    wr(IDX_P7_FUNC, 32'h0000_0020);
    wr(IDX_P7_DIR, 32'h0000_0000);
    wr(IDX_IRQ_MASK, 32'h0000_0001);
    // every mode: idle level, clear, then the active level or edge
    for (int m = 0; m < 4; m++) begin
      wr(IDX_IRQ_MODE, 32'(m));
      ext7[5] <= m[0];
      pause(3);
      wr(IDX_IRQ_STAT, 32'h0000_001f);
      pause(2);
      chk(32'(irq), 32'h0000_0000);
      ext7[5] <= ~m[0];
      pause(4);
      chk(32'(irq), 32'h0000_0001);
      if (m[1]) begin
        chk(32'(eirq[4]), 32'h0000_0001);
      end
    end
    wr(IDX_IRQ_MASK, 32'h0000_0000);
    pause(2);
    chk(32'(irq), 32'h0000_0000);
    // bit 0 set as function output is a reserved combination
    wr(IDX_P8_FUNC, 32'h0000_00ff);
    wr(IDX_P8_DIR, 32'h0000_00cd);
    pause(2);
    chk(32'(p8_oe), 32'h0000_00cc);
    chk(32'(p8_out & 8'hcc), 32'h0000_0084);
    t16 <= 4'h6;
    ext8 <= 8'h33;
    pause(3);
    chk(32'(p8_out & 8'hcc), 32'h0000_0048);
    chk(32'({cap, eirq[3:0]}), 32'h0000_0077);
    rd(IDX_P8_DATA);
    chk(rv, 32'h0000_007b);
    rd(IDX_IRQ_STAT);
    chk(rv, 32'h0000_001d);
    wr(IDX_IRQ_MASK, 32'h0000_001e);
    pause(2);
    chk(32'(irq), 32'h0000_0001);
    wr(IDX_IRQ_STAT, 32'h0000_001e);
    rd(IDX_IRQ_STAT);
    chk(rv, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0000);
    print_verdict();
  end
endmodule
`default_nettype wire
